/* mmbm_consts.svh */
// Named offsets, field positions and reset values of the bus master port.
// Assumes inclusion by bare name from the design files that need it.
`ifndef MMBM_CONSTS_SVH
`define MMBM_CONSTS_SVH

`define MMBM_REG_CTRL 8'h00
`define MMBM_REG_ADDR 8'h04
`define MMBM_REG_WDATA 8'h08
`define MMBM_REG_CFG 8'h0C
`define MMBM_REG_STATUS 8'h10
`define MMBM_REG_RDATA 8'h14

`define MMBM_CTRL_WR 0
`define MMBM_CTRL_RD 1
`define MMBM_CTRL_FLUSH 2
`define MMBM_CTRL_EOPCLR 3

`define MMBM_CFG_BE_LSB 0
`define MMBM_CFG_BC_LSB 8
`define MMBM_CFG_BC_W 6
`define MMBM_CFG_MASK 32'h00003F0F
`define MMBM_CFG_RESET 32'h0000010F

`define MMBM_ST_BUSY 0
`define MMBM_ST_RDV 1
`define MMBM_ST_EOP 2
`define MMBM_ST_IRQ 3
`define MMBM_ST_RFD 4
`define MMBM_ST_DAV 5
`define MMBM_ST_PEND_LSB 8
`define MMBM_ST_IRQN_LSB 16

`define MMBM_RESP_OKAY 2'h0
`define MMBM_RESP_SLVERR 2'h2

`endif

/* mmbm_pkg.sv */
// Types shared by the bus master port: states and configuration choices.
// Assumes nothing of its surroundings.
package mmbm_pkg;

	typedef enum logic [1:0] {
		MMBM_IDLE = 2'h0,
		MMBM_FLOW = 2'h1,
		MMBM_REQ = 2'h3
	} mmbm_state_t;

	typedef enum logic [1:0] {
		MMBM_RD_ONLY = 2'h0,
		MMBM_WR_ONLY = 2'h1,
		MMBM_RD_WR = 2'h2
	} mmbm_access_t;

	typedef enum logic [1:0] {
		MMBM_SINT = 2'h0,
		MMBM_SFRAC = 2'h1,
		MMBM_UINT = 2'h2
	} mmbm_format_t;

	typedef enum logic {
		MMBM_IRQ_PRIO = 1'h0,
		MMBM_IRQ_INDIV = 1'h1
	} mmbm_irqmode_t;

endpackage : mmbm_pkg

/* mmbm_axil.sv */
// AXI4-Lite slave front end: turns bus handshakes into register strobes.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ns
`default_nettype none
`include "mmbm_consts.svh"

module mmbm_axil #(
	parameter int AW = 8
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Write channels
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_en,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_en,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	logic aw_full_reg;
	logic w_full_reg;

	// Ready flags are registered copies of the inverted hold state, so that
	// every bus output leaves from a flip-flop.
	wire aw_full_next = (awvalid && !aw_full_reg) || (aw_full_reg && !wr_en);
	wire w_full_next = (wvalid && !w_full_reg) || (w_full_reg && !wr_en);
	wire rvalid_next = rd_en || (rvalid && !rready);
	// The register write waits until the previous response has been taken.
	assign wr_en = aw_full_reg && w_full_reg && !bvalid;
	assign rd_en = arvalid && !rvalid;
	assign rd_addr = araddr;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			arready <= 1'b1;
		end
		else if (ce)
		begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready <= !aw_full_next;
			wready <= !w_full_next;
			arready <= !rvalid_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_addr <= '0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end
		else if (ce)
		begin
			if (awvalid && !aw_full_reg)
				wr_addr <= awaddr;
			if (wvalid && !w_full_reg)
			begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid <= 1'b0;
			bresp <= `MMBM_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `MMBM_RESP_OKAY;
			rdata <= 32'h00000000;
		end
		else if (ce)
		begin
			if (wr_en)
			begin
				bvalid <= 1'b1;
				bresp <= wr_err ? `MMBM_RESP_SLVERR : `MMBM_RESP_OKAY;
			end
			else if (bready)
				bvalid <= 1'b0;
			if (rd_en)
			begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_err ? `MMBM_RESP_SLVERR : `MMBM_RESP_OKAY;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

endmodule : mmbm_axil
`default_nettype wire

/* mmbm_master.sv */
// Memory-mapped bus master port driven from AXI4-Lite registers.
// Assumes the interconnect is synchronous to CLK; absent optional pins are
// tied off inside and their inputs ignored, except M_READYFORDATA and M_DATAAVAILABLE, which STATUS always shows.
// Operation
// - Hold request and payload while stalled
// - Address is byte address, word aligned
// - Read request exists only for read access
// - Write request exists only for write access
// - Byte lanes only if allowed, writes, wide
// - Reads assert every byte lane
// - Capture read data only when marked valid
// - Flush cancels all pending pipelined reads
// - Burst count gives transfers in burst
// - Maximum burst between 2 and 32
// - Lower interrupt number means higher priority
// - Interrupt mode prioritized or individual lines
// - Address width from 1 to 32
// - Data format signed, fractional or unsigned
// - Integer bits parameter, equal read/write widths
// - Fraction bits only for signed fractional
// - Flow control gates start of transfer
// - Pipelining only with read access
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "mmbm_consts.svh"

module mmbm_master #(
	parameter int ADDR_W = 32,
	parameter mmbm_pkg::mmbm_access_t ACCESS = mmbm_pkg::MMBM_RD_WR,
	parameter mmbm_pkg::mmbm_format_t FMT = mmbm_pkg::MMBM_SINT,
	parameter int INT_BITS = 32,
	parameter int FRAC_BITS = 0,
	parameter bit ALLOW_BE = 1'b1,
	parameter bit FLOW = 1'b0,
	parameter bit PIPELINE = 1'b1,
	parameter bit USE_FLUSH = 1'b1,
	parameter bit BURST = 1'b1,
	parameter int MAX_BURST = 32,
	parameter bit RX_IRQ = 1'b1,
	parameter mmbm_pkg::mmbm_irqmode_t IRQ_MODE = mmbm_pkg::MMBM_IRQ_PRIO,
	parameter int IRQ_W = 8,
	parameter int IRQN_W = 6,
	parameter int AW = 8
) (
	// Clock, reset and enable
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// AXI4-Lite register port
	input wire logic [AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Master requests toward the interconnect
	output logic [ADDR_W-1:0] M_ADDRESS,
	output logic M_READ,
	output logic M_WRITE,
	output logic [INT_BITS+((FMT==mmbm_pkg::MMBM_SFRAC)?FRAC_BITS:0)-1:0] M_WRITEDATA,
	output logic [(INT_BITS+((FMT==mmbm_pkg::MMBM_SFRAC)?FRAC_BITS:0)+7)/8-1:0] M_BYTEENABLE,
	output logic [$clog2(MAX_BURST):0] M_BURSTCOUNT,
	output logic M_FLUSH,
	// Answers and status from the interconnect
	input wire logic M_WAITREQUEST,
	input wire logic [INT_BITS+((FMT==mmbm_pkg::MMBM_SFRAC)?FRAC_BITS:0)-1:0] M_READDATA,
	input wire logic M_READDATAVALID,
	input wire logic M_ENDOFPACKET,
	input wire logic M_READYFORDATA,
	input wire logic M_DATAAVAILABLE,
	input wire logic [IRQ_W-1:0] M_IRQ,
	input wire logic [IRQN_W-1:0] M_IRQNUMBER
);

	// Read and write buses share one width; fraction bits count only when
	// the format is signed fractional.
	localparam int DATA_W = INT_BITS + ((FMT == mmbm_pkg::MMBM_SFRAC) ? FRAC_BITS : 0);
	localparam int BE_W = (DATA_W + 7) / 8;
	localparam int ALIGN_B = (BE_W > 1) ? $clog2(BE_W) : 0;
	localparam int BC_W = $clog2(MAX_BURST) + 1;
	localparam int PEND_W = BC_W + 2;
	localparam bit SIGNED_D = (FMT != mmbm_pkg::MMBM_UINT);
	localparam bit CAN_RD = (ACCESS != mmbm_pkg::MMBM_WR_ONLY);
	localparam bit CAN_WR = (ACCESS != mmbm_pkg::MMBM_RD_ONLY);
	localparam bit BE_EN = ALLOW_BE && CAN_WR && (DATA_W > 8);
	localparam bit PIPE = PIPELINE && CAN_RD;
	localparam bit FLUSH_EN = PIPE && USE_FLUSH;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// The sign bit is the top bit for both signed formats.
	function automatic logic [31:0] ext_data(input logic [DATA_W-1:0] d);
		logic [31:0] r;
		r = {32{SIGNED_D && d[DATA_W-1]}};
		r[DATA_W-1:0] = d;
		return r;
	endfunction : ext_data

	// Lowest set line wins, matching the numbering of the prioritized mode.
	function automatic logic [7:0] first_set(input logic [IRQ_W-1:0] v);
		logic [7:0] n;
		n = 8'h00;
		for (int i = IRQ_W - 1; i >= 0; i--)
			if (v[i])
				n = 8'(i);
		return n;
	endfunction : first_set

	function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = a;
		for (int i = 0; i < ALIGN_B && i < ADDR_W; i++)
			r[i] = 1'b0;
		return r;
	endfunction : align_addr

	logic wr_en;
	logic rd_en;
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] rd_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;
	logic rd_err;
	logic wr_err;

	mmbm_axil #(.AW(AW)) u_axil (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	mmbm_pkg::mmbm_state_t state_reg;
	mmbm_pkg::mmbm_state_t state_next;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] cfg_reg;
	logic [31:0] rdata_reg;
	logic rdv_reg;
	logic eop_reg;
	logic irq_reg;
	logic [7:0] irqn_reg;
	logic dir_reg;
	logic dir_next;
	logic m_read_reg;
	logic m_write_reg;
	logic flush_reg;
	logic [ADDR_W-1:0] addr_out_reg;
	logic [DATA_W-1:0] wdata_out_reg;
	logic [BE_W-1:0] be_cfg_reg;
	logic [BC_W-1:0] bc_out_reg;
	logic [BC_W-1:0] beats_reg;
	logic [PEND_W-1:0] pend_reg;
	logic [PEND_W-1:0] pend_next;

	// Register decode and read mux.
	wire ctrl_wr = wr_en && (wr_addr == `MMBM_REG_CTRL) && wr_strb[0];
	wire cmd_wr = ctrl_wr && wr_data[`MMBM_CTRL_WR];
	wire cmd_rd = ctrl_wr && wr_data[`MMBM_CTRL_RD];
	wire cmd_flush = ctrl_wr && wr_data[`MMBM_CTRL_FLUSH];
	wire cmd_eopclr = ctrl_wr && wr_data[`MMBM_CTRL_EOPCLR];
	wire mapped_w = (wr_addr == `MMBM_REG_CTRL) || (wr_addr == `MMBM_REG_ADDR)
		|| (wr_addr == `MMBM_REG_WDATA) || (wr_addr == `MMBM_REG_CFG)
		|| (wr_addr == `MMBM_REG_STATUS) || (wr_addr == `MMBM_REG_RDATA);
	wire mapped_r = (rd_addr == `MMBM_REG_CTRL) || (rd_addr == `MMBM_REG_ADDR)
		|| (rd_addr == `MMBM_REG_WDATA) || (rd_addr == `MMBM_REG_CFG)
		|| (rd_addr == `MMBM_REG_STATUS) || (rd_addr == `MMBM_REG_RDATA);
	wire busy = (state_reg != mmbm_pkg::MMBM_IDLE) || (pend_reg != '0);
	wire [7:0] pend8 = 8'(pend_reg);
	wire [31:0] status_w = {8'h00, irqn_reg, pend8, 2'h0,
		M_DATAAVAILABLE, M_READYFORDATA, irq_reg, eop_reg, rdv_reg, busy};
	assign wr_err = !mapped_w;
	assign rd_err = !mapped_r;
	assign rd_data = (rd_addr == `MMBM_REG_ADDR) ? addr_reg
		: (rd_addr == `MMBM_REG_WDATA) ? wdata_reg
		: (rd_addr == `MMBM_REG_CFG) ? cfg_reg
		: (rd_addr == `MMBM_REG_STATUS) ? status_w
		: (rd_addr == `MMBM_REG_RDATA) ? rdata_reg
		: 32'h00000000;

	// Transfer sequencing. A flush takes the idle slot, so it never meets a
	// request that is still held on the bus.
	wire is_idle = (state_reg == mmbm_pkg::MMBM_IDLE);
	wire do_flush = FLUSH_EN && cmd_flush && is_idle;
	wire start_wr = CAN_WR && cmd_wr && is_idle && !do_flush;
	wire start_rd = CAN_RD && cmd_rd && is_idle && !do_flush && !start_wr
		&& !pend_reg[PEND_W-1];
	wire flow_ok = !FLOW || (dir_next ? M_READYFORDATA : M_DATAAVAILABLE);
	wire accept = (m_read_reg || m_write_reg) && !M_WAITREQUEST;
	wire last_beat = accept && (m_read_reg || (beats_reg == BC_W'(1)));
	wire rd_acc = accept && m_read_reg;
	wire rdv_take = PIPE ? (M_READDATAVALID && (pend_reg != '0)) : rd_acc;
	wire [5:0] bc_field = cfg_reg[`MMBM_CFG_BC_LSB +: `MMBM_CFG_BC_W];
	wire [BC_W-1:0] bc_cfg = !BURST || (bc_field == 6'h00) ? BC_W'(1)
		: (bc_field > 6'(MAX_BURST)) ? BC_W'(MAX_BURST) : bc_field[BC_W-1:0];
	// Non-pipelined reads move one word per request.
	wire [BC_W-1:0] bc_rd = PIPE ? bc_cfg : BC_W'(1);
	wire [7:0] irq_num = (IRQ_MODE == mmbm_pkg::MMBM_IRQ_PRIO) ? 8'(M_IRQNUMBER)
		: first_set(M_IRQ);
	wire irq_any = RX_IRQ && ((IRQ_MODE == mmbm_pkg::MMBM_IRQ_PRIO) ? M_IRQ[0]
		: |M_IRQ);

	assign dir_next = start_wr ? 1'b1 : (start_rd ? 1'b0 : dir_reg);
	assign pend_next = do_flush ? '0 : pend_reg
		+ ((rd_acc && PIPE) ? PEND_W'(bc_out_reg) : '0)
		- {{(PEND_W-1){1'b0}}, (rdv_take && PIPE)};
	assign state_next = (start_wr || start_rd) ? (flow_ok ? mmbm_pkg::MMBM_REQ
		: mmbm_pkg::MMBM_FLOW)
		: (state_reg == mmbm_pkg::MMBM_FLOW) ? (flow_ok ? mmbm_pkg::MMBM_REQ
		: mmbm_pkg::MMBM_FLOW)
		: (state_reg == mmbm_pkg::MMBM_REQ) ? (last_beat ? mmbm_pkg::MMBM_IDLE
		: mmbm_pkg::MMBM_REQ)
		: mmbm_pkg::MMBM_IDLE;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			addr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			cfg_reg <= `MMBM_CFG_RESET;
		end
		else if (CE && wr_en)
		begin
			case (wr_addr)
				`MMBM_REG_ADDR: addr_reg <= merge(addr_reg, wr_data, wr_strb);
				`MMBM_REG_WDATA: wdata_reg <= merge(wdata_reg, wr_data, wr_strb);
				`MMBM_REG_CFG: cfg_reg <= merge(cfg_reg, wr_data, wr_strb) & `MMBM_CFG_MASK;
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// Valid and end-of-packet flags are sticky, a new event in the clearing cycle winning over the clear; the interrupt flag follows its input.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rdata_reg <= 32'h00000000;
			rdv_reg <= 1'b0;
			eop_reg <= 1'b0;
			irq_reg <= 1'b0;
			irqn_reg <= 8'h00;
		end
		else if (CE)
		begin
			if (rdv_take)
				rdata_reg <= ext_data(M_READDATA);
			rdv_reg <= rdv_take || (rdv_reg && !(rd_en && rd_addr == `MMBM_REG_RDATA));
			eop_reg <= (FLOW && M_ENDOFPACKET) || (eop_reg && !cmd_eopclr);
			irq_reg <= irq_any;
			irqn_reg <= irq_any ? irq_num : 8'h00;
		end
	end

	// Payload is snapshot at start so software edits cannot move it mid-stall.
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			addr_out_reg <= '0;
			wdata_out_reg <= '0;
			be_cfg_reg <= '1;
			bc_out_reg <= BC_W'(1);
		end
		else if (CE && (start_wr || start_rd))
		begin
			addr_out_reg <= align_addr(addr_reg[ADDR_W-1:0]);
			wdata_out_reg <= wdata_reg[DATA_W-1:0];
			// Reads always present every byte lane, whatever the lane setting.
			be_cfg_reg <= (BE_EN && start_wr) ? cfg_reg[`MMBM_CFG_BE_LSB +: BE_W] : '1;
			bc_out_reg <= start_wr ? bc_cfg : bc_rd;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_reg <= mmbm_pkg::MMBM_IDLE;
			dir_reg <= 1'b0;
			m_read_reg <= 1'b0;
			m_write_reg <= 1'b0;
			flush_reg <= 1'b0;
			beats_reg <= BC_W'(1);
			pend_reg <= '0;
		end
		else if (CE)
		begin
			state_reg <= state_next;
			dir_reg <= dir_next;
			m_write_reg <= (state_next == mmbm_pkg::MMBM_REQ) && dir_next;
			m_read_reg <= (state_next == mmbm_pkg::MMBM_REQ) && !dir_next;
			flush_reg <= do_flush;
			beats_reg <= start_wr ? bc_cfg
				: (accept && m_write_reg) ? beats_reg - BC_W'(1) : beats_reg;
			pend_reg <= pend_next;
		end
	end

	assign M_ADDRESS = addr_out_reg;
	assign M_READ = m_read_reg;
	assign M_WRITE = m_write_reg;
	assign M_WRITEDATA = wdata_out_reg;
	assign M_BYTEENABLE = be_cfg_reg;
	assign M_BURSTCOUNT = bc_out_reg;
	assign M_FLUSH = flush_reg;

	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	hold_stall_a: assert property (
		(M_READ || M_WRITE) && M_WAITREQUEST |=> $stable(M_ADDRESS) && $stable(M_READ)
		&& $stable(M_WRITE) && $stable(M_WRITEDATA) && $stable(M_BURSTCOUNT)
		&& $stable(M_BYTEENABLE))
		else $error("request changed while stalled");
	addr_align_a: assert property (
		(M_READ || M_WRITE) |-> (M_ADDRESS == align_addr(M_ADDRESS)))
		else $error("address not word aligned");
	access_gate_a: assert property (
		!(M_READ && !CAN_RD) && !(M_WRITE && !CAN_WR))
		else $error("request on a disabled direction");
	read_lanes_a: assert property (
		M_READ || (M_WRITE && !BE_EN) |-> (&M_BYTEENABLE))
		else $error("byte lanes not all enabled");
	rdv_capture_a: assert property (
		CE && rdv_take |=> rdata_reg == ext_data($past(M_READDATA)))
		else $error("read data not captured");
	flush_clear_a: assert property (
		M_FLUSH |-> pend_reg == '0 && !M_READ && FLUSH_EN)
		else $error("flush left reads pending");
	burst_end_a: assert property (
		CE && accept && M_WRITE && beats_reg == BC_W'(1) |=> !M_WRITE)
		else $error("write burst overran its count");
	burst_more_a: assert property (
		CE && accept && M_WRITE && beats_reg > BC_W'(1) |=> M_WRITE ##0 $stable(M_ADDRESS))
		else $error("write burst ended early");
	flow_start_a: assert property (
		$rose(M_WRITE) |-> !FLOW || $past(M_READYFORDATA))
		else $error("write started without slave ready");
	asked_start_a: assert property (
		$rose(M_READ) || $rose(M_WRITE) |->
		$past(start_rd) || $past(start_wr) || ($past(state_reg) == mmbm_pkg::MMBM_FLOW))
		else $error("request raised without command");

	write_done_c: cover property (accept && M_WRITE && beats_reg == BC_W'(1));
	stall_write_c: cover property (M_WRITE && M_WAITREQUEST ##1 M_WRITE && !M_WAITREQUEST);
	pipe_read_c: cover property (PIPE && M_READDATAVALID && pend_reg > PEND_W'(1));
	flush_c: cover property (M_FLUSH);

endmodule : mmbm_master
`default_nettype wire

/* mmbm_slave_model.sv */
// Behavioural interconnect slave that answers the bus master port.
// Assumes the default port widths: 32-bit address and data, 6-bit burst count.
`timescale 1ns/1ns
`default_nettype none

module mmbm_slave_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench controls
	input wire logic [3:0] stall,
	input wire logic [5:0] lat,
	// Requests from the master
	input wire logic [31:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [5:0] burstcount,
	input wire logic flush,
	// Answers to the master
	output logic waitrequest,
	output logic [31:0] readdata,
	output logic readdatavalid,
	// Observations for the bench
	output logic [7:0] wr_beats,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_be,
	output logic [3:0] rd_be,
	output logic [5:0] rd_bc
);
	logic [3:0] cnt;
	logic [5:0] left;
	logic [5:0] timer;
	logic [4:0] idx;
	logic [15:0] base;

	// Every request is stalled for a set number of cycles, as a slow slave.
	assign waitrequest = (read | write) && (cnt != stall);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 4'h0;
			left <= 6'h00;
			timer <= 6'h00;
			idx <= 5'h00;
			base <= 16'h0000;
			readdata <= 32'h00000000;
			readdatavalid <= 1'b0;
			wr_beats <= 8'h00;
			wr_addr <= 32'h00000000;
			wr_data <= 32'h00000000;
			wr_be <= 4'h0;
			rd_be <= 4'h0;
			rd_bc <= 6'h00;
		end
		else
		begin
			cnt <= ((read | write) && waitrequest) ? cnt + 4'h1 : 4'h0;
			readdatavalid <= 1'b0;
			if (write && !waitrequest)
			begin
				wr_beats <= wr_beats + 8'h01;
				wr_addr <= address;
				wr_data <= writedata;
				wr_be <= byteenable;
			end
			if (left != 6'h00 && timer != 6'h00)
				timer <= timer - 6'h01;
			else if (left != 6'h00)
			begin
				readdatavalid <= 1'b1;
				readdata <= {base, 11'h000, idx};
				idx <= idx + 5'h01;
				left <= left - 6'h01;
			end
			else
				// Stale data is scrambled so a capture outside valid shows.
				readdata <= ~readdata;
			if (read && !waitrequest)
			begin
				left <= burstcount;
				timer <= lat;
				idx <= 5'h00;
				base <= address[15:0];
				rd_be <= byteenable;
				rd_bc <= burstcount;
			end
			if (flush)
				left <= 6'h00;
		end
	end

endmodule : mmbm_slave_model
`default_nettype wire

/* memory_mapped_bus_master_port_bench.sv */
// Self-checking bench for the bus master port, driven over AXI4-Lite.
// Assumes the design's default parameters and the slave model beside it.
`timescale 1ns/1ns
`default_nettype none
`include "mmbm_consts.svh"

module memory_mapped_bus_master_port_bench;
	logic clk;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] m_irq = 8'h00;
	logic m_eop = 1'b0;
	logic [5:0] m_irqn = 6'h00;
	logic [3:0] stall = 4'h0;
	logic [5:0] lat = 6'h00;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, m_addr, m_wdata, m_rdata, wr_addr, wr_data;
	logic m_read, m_write, m_flush, m_wait, m_rvalid;
	logic [3:0] m_be, wr_be, rd_be;
	logic [5:0] m_bc, rd_bc;
	logic [7:0] wr_beats;
	int err_count = 0;
	int tests_run = 0;
	int flush_cnt = 0;

	mmbm_master DUT (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .M_ADDRESS(m_addr),
		.M_READ(m_read), .M_WRITE(m_write), .M_WRITEDATA(m_wdata),
		.M_BYTEENABLE(m_be), .M_BURSTCOUNT(m_bc), .M_FLUSH(m_flush),
		.M_WAITREQUEST(m_wait), .M_READDATA(m_rdata),
		.M_READDATAVALID(m_rvalid), .M_ENDOFPACKET(m_eop),
		.M_READYFORDATA(1'b1), .M_DATAAVAILABLE(1'b1), .M_IRQ(m_irq),
		.M_IRQNUMBER(m_irqn));

	mmbm_slave_model slave (.clk(clk), .rst_n(rst_n), .stall(stall),
		.lat(lat), .address(m_addr), .read(m_read), .write(m_write),
		.writedata(m_wdata), .byteenable(m_be), .burstcount(m_bc),
		.flush(m_flush), .waitrequest(m_wait), .readdata(m_rdata),
		.readdatavalid(m_rvalid), .wr_beats(wr_beats), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_be(wr_be), .rd_be(rd_be), .rd_bc(rd_bc));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (m_flush === 1'b1)
			flush_cnt <= flush_cnt + 1;

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit got;
		got = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got)
		begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				got = 1'b1;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, 32'h00000000);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit got;
		got = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got)
		begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				got = 1'b1;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : axi_rd

	task automatic wait_idle();
		logic [31:0] st;
		logic [1:0] r;
		st = 32'h00000001;
		for (int i = 0; i < 50 && st[0] !== 1'b0; i++)
			axi_rd(`MMBM_REG_STATUS, st, r);
	endtask : wait_idle

	task automatic test_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk("requests", {29'h0, m_read, m_write, m_flush}, 32'h0);
		axi_rd(`MMBM_REG_CFG, d, r);
		chk("cfg reset", d, `MMBM_CFG_RESET);
		axi_rd(`MMBM_REG_ADDR, d, r);
		chk("addr reset", d, 32'h00000000);
		axi_rd(8'h20, d, r);
		chk("unmapped resp", {30'h0, r}, 32'h00000002);
		$display("test reset done");
	endtask : test_reset

	task automatic test_write();
		logic [7:0] b0;
		b0 = wr_beats;
		stall <= 4'h2;
		axi_wr(`MMBM_REG_ADDR, 32'h00001003);
		axi_wr(`MMBM_REG_WDATA, 32'hA5C30F96);
		axi_wr(`MMBM_REG_CFG, 32'h00000205);
		axi_wr(`MMBM_REG_CTRL, 32'h00000001);
		wait_idle();
		chk("write beats", {24'h0, wr_beats - b0}, 32'h00000002);
		chk("write addr", wr_addr, 32'h00001000);
		chk("write data", wr_data, 32'hA5C30F96);
		chk("write lanes", {28'h0, wr_be}, 32'h00000005);
		$display("test write burst done");
	endtask : test_write

	task automatic test_read();
		logic [31:0] d;
		logic [1:0] r;
		stall <= 4'h1;
		lat <= 6'h03;
		axi_wr(`MMBM_REG_ADDR, 32'h00002000);
		axi_wr(`MMBM_REG_CFG, 32'h00000405);
		axi_wr(`MMBM_REG_CTRL, 32'h00000002);
		wait_idle();
		chk("read lanes", {28'h0, rd_be}, 32'h0000000F);
		chk("read count", {26'h0, rd_bc}, 32'h00000004);
		axi_rd(`MMBM_REG_RDATA, d, r);
		chk("read data", d, 32'h20000003);
		axi_rd(`MMBM_REG_STATUS, d, r);
		chk("valid cleared", d & 32'h0000FF02, 32'h00000000);
		$display("test pipelined read done");
	endtask : test_read

	task automatic test_flush();
		logic [31:0] d;
		logic [1:0] r;
		int f0;
		lat <= 6'h1E;
		axi_wr(`MMBM_REG_CTRL, 32'h00000002);
		repeat (3) @(posedge clk);
		axi_rd(`MMBM_REG_STATUS, d, r);
		chk("pending", {24'h0, d[15:8]}, 32'h00000004);
		f0 = flush_cnt;
		axi_wr(`MMBM_REG_CTRL, 32'h00000004);
		repeat (40) @(posedge clk);
		axi_rd(`MMBM_REG_STATUS, d, r);
		chk("flushed", d & 32'h0000FF03, 32'h00000000);
		chk("flush pulse", flush_cnt - f0, 32'h00000001);
		$display("test flush done");
	endtask : test_flush

	task automatic test_irq();
		logic [31:0] d;
		logic [1:0] r;
		m_irq <= 8'h01;
		m_irqn <= 6'h05;
		// Flow control is off, so the end-of-packet input must be ignored.
		m_eop <= 1'b1;
		repeat (2) @(posedge clk);
		axi_rd(`MMBM_REG_STATUS, d, r);
		chk("irq seen", d & 32'h00FF000C, 32'h00050008);
		m_irq <= 8'h00;
		m_eop <= 1'b0;
		repeat (2) @(posedge clk);
		axi_rd(`MMBM_REG_STATUS, d, r);
		chk("irq gone", d & 32'h00FF0008, 32'h00000000);
		$display("test interrupt done");
	endtask : test_irq

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_reset();
		test_write();
		test_read();
		test_flush();
		test_irq();
		conclude();
	end

	// The tests need under two hundred cycles; this span leaves ample margin.
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		conclude();
	end

endmodule : memory_mapped_bus_master_port_bench
`default_nettype wire
